// ==== pdvb_core.v ====
`timescale 1ns/1ps
`include "pdvb_map.vh"
module pdvb_core (
  input wire clk,
  input wire srst,
  input wire mode_found,
  input wire enter_ack,
  input wire exit_ack,
  input wire exit_req,
  input wire hard_reset,
  input wire detach,
  input wire pd_seq_busy,
  input wire pd_msg_in,
  input wire goodcrc_done,
  input wire vdm_tx_fail,
  input wire vdm_want,
  input wire vdm_done,
  input wire bat_req,
  input wire [2:0] bat_ref,
  input wire [7:0] bat_exists,
  input wire [7:0] bat_hotswap,
  input wire [7:0] bat_attached,
  input wire [15:0] bat_cap_flat0,
  input wire [15:0] bat_cap_flat1,
  input wire [15:0] bat_cap_flat2,
  input wire [15:0] bat_cap_flat3,
  input wire [15:0] bat_cap_flat4,
  input wire [15:0] bat_cap_flat5,
  input wire [15:0] bat_cap_flat6,
  input wire [15:0] bat_cap_flat7,
  input wire [15:0] bat_chg_flat,
  output reg mode_active_r,
  output reg usb_normal_r,
  output reg enter_cmd_r,
  output reg exit_cmd_r,
  output reg vdm_start_r,
  output reg vdm_pending_r,
  output reg bat_reply_r,
  output reg [2:0] bat_ndo_r,
  output reg [31:0] bat_obj_r
);
  localparam ST_USB = 6'h01;
  localparam ST_ENTER = 6'h02;
  localparam ST_ACTIVE = 6'h04;
  localparam ST_EXIT = 6'h08;
  localparam ST_VDM = 6'h10;
  localparam ST_HOLD = 6'h20;

  reg [5:0] state_r;
  reg [5:0] state_nxt;
  reg crc_wait_r;
  wire [15:0] cap_sel;
  wire [1:0] chg_sel [0:7];
  wire [15:0] cap_arr [0:7];
  wire unmanaged;
  wire ref_ok;
  wire present;
  wire [1:0] chg;
  reg [7:0] info;
  reg [15:0] cap;
  wire [1:0] code_all [0:7];
  wire [7:0] pres_all;
  wire [31:0] obj_word;

  wire in_usb;
  wire in_enter;
  wire in_active;
  wire in_exit;
  wire in_vdm;
  wire in_hold;
  wire go_enter;
  wire go_active;
  wire go_exit;
  wire go_vdm;
  wire go_hold;
  wire go_back;
  wire go_rerun;
  wire go_usb;
  wire vdm_entry;

  wire crc_wait_nxt;
  wire mode_active_nxt;
  wire usb_normal_nxt;
  wire enter_cmd_nxt;
  wire exit_cmd_nxt;
  wire vdm_start_nxt;
  wire vdm_pending_nxt;
  wire bat_reply_nxt;
  wire [2:0] bat_ndo_nxt;
  wire [31:0] bat_obj_nxt;

  assign cap_arr[0] = bat_cap_flat0;
  assign cap_arr[1] = bat_cap_flat1;
  assign cap_arr[2] = bat_cap_flat2;
  assign cap_arr[3] = bat_cap_flat3;
  assign cap_arr[4] = bat_cap_flat4;
  assign cap_arr[5] = bat_cap_flat5;
  assign cap_arr[6] = bat_cap_flat6;
  assign cap_arr[7] = bat_cap_flat7;

  genvar gi;
  generate
    for (gi = 0; gi < `PDVB_NBAT; gi = gi + 1) begin : g_chg
      assign chg_sel[gi] = bat_chg_flat[2*gi+1:2*gi];
      assign pres_all[gi] = ~bat_hotswap[gi] | bat_attached[gi];
      // Reserved code 11 is folded to idle so it can never reach the wire
      assign code_all[gi] = (chg_sel[gi] == 2'h3) ? `PDVB_CHG_IDLE : chg_sel[gi];
    end
  endgenerate

  assign unmanaged = hard_reset | detach;
  assign cap_sel = cap_arr[bat_ref];
  assign ref_ok = bat_exists[bat_ref];
  assign present = pres_all[bat_ref];
  assign chg = code_all[bat_ref];

  // Object built from live inputs in the request cycle, so info is never stale
  always @* begin
    info = 8'h00;
    cap = cap_sel;
    if (!ref_ok) begin
      info[`PDVB_INFO_INVALID] = 1'b1;
      cap = `PDVB_CAP_UNKNOWN;
    end else begin
      info[`PDVB_INFO_PRESENT] = present;
      if (present) begin
        info[3:2] = chg;
      end else begin
        info[3:2] = 2'h0;
      end
    end
  end

  // One-hot flags keep the transition terms short
  assign in_usb = state_r[0];
  assign in_enter = state_r[1];
  assign in_active = state_r[2];
  assign in_exit = state_r[3];
  assign in_vdm = state_r[4];
  assign in_hold = state_r[5];

  assign go_enter = in_usb & mode_found & ~pd_seq_busy;
  assign go_active = in_enter & enter_ack;
  assign go_exit = in_active & exit_req & ~pd_seq_busy;
  // Managed exit wins over a vendor request raised in the same cycle
  assign go_vdm = in_active & ~exit_req & vdm_want & ~pd_seq_busy;
  // A message landing before the GoodCRC is back cannot break the sequence
  assign go_hold = in_vdm & (vdm_tx_fail | (pd_msg_in & ~crc_wait_r));
  assign go_back = in_vdm & ~go_hold & vdm_done;
  // No immediate retry of a failed message: rerun only once the link is quiet again
  assign go_rerun = in_hold & ~pd_seq_busy & ~pd_msg_in;
  assign go_usb = in_exit & exit_ack;

  always @* begin
    state_nxt = state_r;
    case (state_r)
      ST_USB: begin
        if (go_enter) begin
          state_nxt = ST_ENTER;
        end else begin
          state_nxt = ST_USB;
        end
      end
      ST_ENTER: begin
        if (go_active) begin
          state_nxt = ST_ACTIVE;
        end else begin
          state_nxt = ST_ENTER;
        end
      end
      ST_ACTIVE: begin
        if (go_exit) begin
          state_nxt = ST_EXIT;
        end else if (go_vdm) begin
          state_nxt = ST_VDM;
        end else begin
          state_nxt = ST_ACTIVE;
        end
      end
      ST_EXIT: begin
        if (go_usb) begin
          state_nxt = ST_USB;
        end else begin
          state_nxt = ST_EXIT;
        end
      end
      ST_VDM: begin
        if (go_hold) begin
          state_nxt = ST_HOLD;
        end else if (go_back) begin
          state_nxt = ST_ACTIVE;
        end else begin
          state_nxt = ST_VDM;
        end
      end
      ST_HOLD: begin
        if (go_rerun) begin
          state_nxt = ST_VDM;
        end else begin
          state_nxt = ST_HOLD;
        end
      end
      // Illegal codes fall back to USB rather than lock up
      default: begin
        state_nxt = ST_USB;
      end
    endcase
    if (unmanaged) begin
      state_nxt = ST_USB;
    end
  end

  assign vdm_entry = (state_nxt == ST_VDM) & ~in_vdm;
  // Flag set on entry wins over a GoodCRC in the same cycle
  assign crc_wait_nxt = vdm_entry | (crc_wait_r & ~goodcrc_done);
  assign mode_active_nxt = (state_nxt == ST_ACTIVE) | (state_nxt == ST_VDM) | (state_nxt == ST_HOLD) |
                           (state_nxt == ST_EXIT);
  assign usb_normal_nxt = (state_nxt == ST_USB) | (state_nxt == ST_ENTER);
  assign enter_cmd_nxt = go_enter & ~unmanaged;
  assign exit_cmd_nxt = go_exit & ~unmanaged;
  assign vdm_start_nxt = vdm_entry;
  assign vdm_pending_nxt = (state_nxt == ST_HOLD);
  assign bat_reply_nxt = bat_req;
  assign obj_word = {cap, info, 8'h00};
  assign bat_ndo_nxt = bat_req ? `PDVB_NDO_ONE : bat_ndo_r;
  assign bat_obj_nxt = bat_req ? obj_word : bat_obj_r;

  // Rest state after reset is plain USB operation
  always @(posedge clk) begin
    if (srst) begin
      state_r <= `PDVB_RST_STATE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Vendor message counts as in flight until its GoodCRC returns
  always @(posedge clk) begin
    if (srst) begin
      crc_wait_r <= 1'b0;
    end else begin
      crc_wait_r <= crc_wait_nxt;
    end
  end

  // Mode stays active through vendor traffic, pre-emption and the exit handshake
  always @(posedge clk) begin
    if (srst) begin
      mode_active_r <= 1'b0;
    end else begin
      mode_active_r <= mode_active_nxt;
    end
  end

  // Normal USB operation holds until the partner acknowledges entry
  always @(posedge clk) begin
    if (srst) begin
      usb_normal_r <= 1'b1;
    end else begin
      usb_normal_r <= usb_normal_nxt;
    end
  end

  // Command pulses are one cycle wide
  always @(posedge clk) begin
    if (srst) begin
      enter_cmd_r <= 1'b0;
    end else begin
      enter_cmd_r <= enter_cmd_nxt;
    end
  end

  always @(posedge clk) begin
    if (srst) begin
      exit_cmd_r <= 1'b0;
    end else begin
      exit_cmd_r <= exit_cmd_nxt;
    end
  end

  // Pulses on every entry to the vendor state, reruns included
  always @(posedge clk) begin
    if (srst) begin
      vdm_start_r <= 1'b0;
    end else begin
      vdm_start_r <= vdm_start_nxt;
    end
  end

  // Level so that the policy layer knows a rerun is owed
  always @(posedge clk) begin
    if (srst) begin
      vdm_pending_r <= 1'b0;
    end else begin
      vdm_pending_r <= vdm_pending_nxt;
    end
  end

  // Reply pulse lags the request by exactly one cycle
  always @(posedge clk) begin
    if (srst) begin
      bat_reply_r <= 1'b0;
    end else begin
      bat_reply_r <= bat_reply_nxt;
    end
  end

  // Count and object hold until the next request so a slow reader still sees them
  always @(posedge clk) begin
    if (srst) begin
      bat_ndo_r <= 3'h0;
    end else begin
      bat_ndo_r <= bat_ndo_nxt;
    end
  end

  always @(posedge clk) begin
    if (srst) begin
      bat_obj_r <= `PDVB_RST_OBJ;
    end else begin
      bat_obj_r <= bat_obj_nxt;
    end
  end
endmodule

// ==== pdvb_map.vh ====
`ifndef PDVB_MAP_VH
`define PDVB_MAP_VH
`define PDVB_NDO_ONE 3'h1
`define PDVB_CAP_MSB 31
`define PDVB_CAP_LSB 16
`define PDVB_CAP_UNKNOWN 16'hFFFF
`define PDVB_INFO_MSB 15
`define PDVB_INFO_LSB 8
`define PDVB_INFO_INVALID 0
`define PDVB_INFO_PRESENT 1
`define PDVB_CHG_CHARGING 2'h0
`define PDVB_CHG_DISCHARGING 2'h1
`define PDVB_CHG_IDLE 2'h2
`define PDVB_NBAT 8
`define PDVB_REF_W 3
`define PDVB_RST_OBJ 32'h00000000
`define PDVB_RST_STATE 6'h01
`endif

// ==== pdvb_monitor.sv ====
`timescale 1ns/1ps
module pdvb_monitor (
  input wire clk, input wire srst, input wire bat_req, input wire [2:0] bat_ref,
  input wire [7:0] bat_exists, input wire hard_reset, input wire detach, input wire pd_seq_busy,
  input wire bat_reply_r, input wire [2:0] bat_ndo_r, input wire [31:0] bat_obj_r,
  input wire mode_active_r, input wire vdm_start_r
);
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  property p_reply; bat_req |=> bat_reply_r; endproperty
  a_reply: assert property (p_reply) else $error("request not answered");
  property p_only; bat_reply_r |-> $past(bat_req); endproperty
  a_only: assert property (p_only) else $error("unsolicited reply");
  property p_ndo; bat_reply_r |-> bat_ndo_r == 3'h1; endproperty
  a_ndo: assert property (p_ndo) else $error("object count wrong");
  property p_rsv; bat_reply_r |-> bat_obj_r[7:0] == 8'h00 && bat_obj_r[15:12] == 4'h0; endproperty
  a_rsv: assert property (p_rsv) else $error("reserved bits set");
  property p_bad; bat_req && !bat_exists[bat_ref] |=> bat_obj_r[31:8] == 24'hFFFF01; endproperty
  a_bad: assert property (p_bad) else $error("bad reference not flagged");
  property p_good; bat_req && bat_exists[bat_ref] |=> !bat_obj_r[8]; endproperty
  a_good: assert property (p_good) else $error("good reference flagged");
  property p_abs; bat_reply_r && !bat_obj_r[9] |-> bat_obj_r[11:10] == 2'h0; endproperty
  a_abs: assert property (p_abs) else $error("absent battery has status");
  property p_c3; bat_reply_r |-> bat_obj_r[11:10] != 2'h3; endproperty
  a_c3: assert property (p_c3) else $error("reserved charge code");
  property p_hr; hard_reset || detach |=> !mode_active_r; endproperty
  a_hr: assert property (p_hr) else $error("mode kept after reset");
  property p_vdm; vdm_start_r |-> !$past(pd_seq_busy); endproperty
  a_vdm: assert property (p_vdm) else $error("vendor start in sequence");
  cover property (bat_reply_r && bat_obj_r[8]);
  cover property (bat_req ##1 bat_req);
  cover property (mode_active_r ##1 vdm_start_r);
endmodule
bind pdvb_core pdvb_monitor u_mon (.*);

// ==== pdvb_partner.sv ====
`timescale 1ns/1ps
module pdvb_partner #(parameter DLY = 1) (
  input wire clk, input wire enter_cmd_r, input wire exit_cmd_r, output reg enter_ack, output reg exit_ack);
  // Acks lag the command by DLY + 1 cycles so that a slow partner is exercised too
  reg [7:0] ent_q = 8'h00;
  reg [7:0] ext_q = 8'h00;
  initial enter_ack = 1'b0;
  initial exit_ack = 1'b0;
  always @(posedge clk) begin
    ent_q <= {ent_q[6:0], enter_cmd_r};
    ext_q <= {ext_q[6:0], exit_cmd_r};
    enter_ack <= ent_q[DLY - 1];
    exit_ack <= ext_q[DLY - 1];
  end
endmodule

// ==== tb.sv ====
`timescale 1ns/1ps
module tb;
  logic clk = 0, srst = 1, bat_req = 0, mode_found = 0, exit_req = 0, hard_reset = 0, detach = 0;
  logic pd_seq_busy = 0, pd_msg_in = 0, goodcrc_done = 0, vdm_tx_fail = 0, vdm_want = 0, vdm_done = 0;
  logic [2:0] bat_ref = 3'h0;
  logic [7:0] bat_exists = 8'h7F, bat_hotswap = 8'h0C, bat_attached = 8'h04;
  logic [15:0] bat_chg_flat = 16'hF9E4;
  logic [15:0] cap [8];
  wire enter_ack, exit_ack, mode_active_r, usb_normal_r, enter_cmd_r, exit_cmd_r;
  wire vdm_start_r, vdm_pending_r, bat_reply_r;
  wire [2:0] bat_ndo_r;
  wire [31:0] bat_obj_r;
  int n_errors = 0, n_checks = 0, i, k;
  initial forever #2.5 clk = ~clk;
  pdvb_partner #(.DLY(3)) u_pp (.*);
  pdvb_core DUT (.*, .bat_cap_flat0(cap[0]), .bat_cap_flat1(cap[1]), .bat_cap_flat2(cap[2]),
    .bat_cap_flat3(cap[3]), .bat_cap_flat4(cap[4]), .bat_cap_flat5(cap[5]), .bat_cap_flat6(cap[6]),
    .bat_cap_flat7(cap[7]));
  function logic [31:0] exp_obj(input int r);
    logic p;
    logic [1:0] c;
    p = !bat_hotswap[r] || bat_attached[r];
    c = bat_chg_flat[2*r +: 2];
    if (c == 2'h3) c = 2'h2;
    if (!p) c = 2'h0;
    return bat_exists[r] ? {cap[r], 4'h0, c, p, 1'b0, 8'h00} : 32'hFFFF0100;
  endfunction
  task chk(input logic [35:0] got, input logic [35:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task finish_test;
    $display("errors %0d checks %0d", n_errors, n_checks);
    if (n_errors == 0 && n_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task enter;
    @(posedge clk) mode_found <= 1;
    for (k = 0; k < 40 && mode_active_r !== 1'b1; k++) @(negedge clk);
    @(posedge clk) mode_found <= 0;
  endtask
  initial begin
    #50000;
    n_errors++;
    finish_test;
  end
  initial begin
    foreach (cap[j]) cap[j] = {j[7:0], 8'hA5};
    repeat (2) @(posedge clk);
    srst <= 0;
    repeat (2) begin
      for (i = 0; i < 9; i++) begin
        @(posedge clk) bat_req <= (i < 8);
        bat_ref <= i[2:0];
        #1 if (i > 0) chk({bat_reply_r, bat_ndo_r, bat_obj_r}, {4'h9, exp_obj(i - 1)});
      end
      @(posedge clk) bat_attached <= 8'h0C;
      #1 chk(bat_reply_r, 0);
    end
    enter;
    @(negedge clk) chk(usb_normal_r, 0);
    @(posedge clk) vdm_want <= 1;
    for (k = 0; k < 20 && vdm_start_r !== 1'b1; k++) @(negedge clk);
    @(posedge clk) vdm_want <= 0;
    goodcrc_done <= 1;
    pd_msg_in <= 1;
    @(posedge clk) goodcrc_done <= 0;
    pd_seq_busy <= 1;
    @(negedge clk) chk(vdm_pending_r, 0);
    @(posedge clk) pd_msg_in <= 0;
    for (k = 0; k < 20 && vdm_pending_r !== 1'b1; k++) @(negedge clk);
    chk(vdm_pending_r, 1);
    @(posedge clk) pd_seq_busy <= 0;
    for (k = 0; k < 20 && vdm_start_r !== 1'b1; k++) @(negedge clk);
    chk({vdm_start_r, mode_active_r}, 2'h3);
    @(posedge clk) vdm_tx_fail <= 1;
    @(posedge clk) vdm_tx_fail <= 0;
    @(negedge clk) chk({vdm_pending_r, mode_active_r}, 2'h3);
    for (k = 0; k < 20 && vdm_start_r !== 1'b1; k++) @(negedge clk);
    @(posedge clk) vdm_done <= 1;
    @(posedge clk) vdm_done <= 0;
    exit_req <= 1;
    for (k = 0; k < 40 && mode_active_r !== 1'b0; k++) @(negedge clk);
    @(posedge clk) exit_req <= 0;
    @(negedge clk) chk(usb_normal_r, 1);
    for (i = 1; i < 3; i++) begin
      enter;
      @(posedge clk) {hard_reset, detach} <= i[1:0];
      @(posedge clk) {hard_reset, detach} <= 2'h0;
      @(negedge clk) chk({mode_active_r, usb_normal_r}, 2'h1);
    end
    finish_test;
  end
endmodule
